// ===== rtl/adc_device_end.sv
`timescale 1ns/1ps
module adc_device_end
  import adc_port_pkg::*;
#(
  parameter int MODE_STABLE = MODE_STABLE_CYCLES,
  parameter int SAMPLE_W = 28
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  adc_link_if.device link,
  input wire logic [1:0] mode_pin,
  input wire logic format_pin,
  input wire logic sync_powerdown_n,
  input wire logic signed [SAMPLE_W-1:0] sample_in,
  output logic sample_take,
  output op_mode_t active_mode,
  output logic settled
);

  localparam int ACC_W = SAMPLE_W + 7;
  localparam int NPIN = 7;

  function automatic logic [7:0] osr_of(input op_mode_t m);
    osr_of = (m == MODE_HR) ? OSR_HR : OSR_HS_LP;
  endfunction

  function automatic logic [2:0] shift_of(input op_mode_t m);
    shift_of = (m == MODE_HR) ? OSR_SHIFT_HR : OSR_SHIFT_HS_LP;
  endfunction

  function automatic logic [2:0] div_of(input op_mode_t m);
    case (m)
      MODE_HR: div_of = MOD_DIV_HR;
      MODE_LP: div_of = MOD_DIV_LP;
      default: div_of = MOD_DIV_HS;
    endcase
  endfunction

  function automatic logic [6:0] settle_of(input op_mode_t m);
    settle_of = (m == MODE_HR) ? SETTLE_HR : SETTLE_HS_LP;
  endfunction

  function automatic op_mode_t decode_mode(input logic [1:0] code);
    case (code)
      MODE_PIN_HR: decode_mode = MODE_HR;
      MODE_PIN_LP: decode_mode = MODE_LP;
      default: decode_mode = MODE_HS;
    endcase
  endfunction

  function automatic logic [23:0] clip_result(input logic signed [ACC_W-1:0] v);
    if (v > ACC_W'(CODE_MAX))
      clip_result = CODE_MAX;
    else if (v < ACC_W'(CODE_MIN))
      clip_result = CODE_MIN;
    else
      clip_result = v[23:0];
  endfunction

  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  logic [1:0] mode_s;
  logic format_s;
  logic spd_s;
  logic sclk_s;
  logic chain_s;
  logic strobe_s;
  logic sclk_prev;
  logic strobe_prev;
  logic sclk_rise;
  logic sclk_fall;
  logic strobe_rise;
  logic [1:0] mode_prev;
  logic [13:0] stable_cnt;
  logic mode_change;
  logic restart;
  logic [2:0] div_cnt;
  logic signed [ACC_W-1:0] acc;
  logic signed [ACC_W-1:0] next_acc;
  logic [7:0] sample_cnt;
  logic [23:0] result_word;
  logic conv_done;
  logic [6:0] conv_cnt;
  logic publish;
  ready_state_t ready_state;
  logic [23:0] shifter;

  // External pins pass two flip-flops; only the second stage feeds logic.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      // The shared ready/frame line idles high, so its stages start high to avoid a false strobe edge.
      pin_meta <= 7'h01;
      pin_sync <= 7'h01;
    end
    else
    begin
      pin_meta <= {mode_pin, format_pin, sync_powerdown_n, link.sclk, link.chain_in, link.ready_or_frame_pin};
      pin_sync <= pin_meta;
    end
  end

  assign mode_s = pin_sync[6:5];
  assign format_s = pin_sync[4];
  assign spd_s = pin_sync[3];
  assign sclk_s = pin_sync[2];
  assign chain_s = pin_sync[1];
  assign strobe_s = pin_sync[0];

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sclk_prev <= 1'b0;
      strobe_prev <= 1'b1;
    end
    else
    begin
      sclk_prev <= sclk_s;
      strobe_prev <= strobe_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_prev;
  assign sclk_fall = !sclk_s && sclk_prev;
  assign strobe_rise = strobe_s && !strobe_prev;

  // A new mode code is taken only after it has held for the full stability count.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      mode_prev <= MODE_PIN_HS;
      stable_cnt <= '0;
      active_mode <= MODE_HS;
      mode_change <= 1'b0;
    end
    else
    begin
      mode_prev <= mode_s;
      mode_change <= 1'b0;
      if (mode_s != mode_prev)
        stable_cnt <= '0;
      else if (decode_mode(mode_s) != active_mode)
      begin
        if (stable_cnt == 14'(MODE_STABLE - 1))
        begin
          active_mode <= decode_mode(mode_s);
          mode_change <= 1'b1;
          stable_cnt <= '0;
        end
        else
          stable_cnt <= stable_cnt + 14'h0001;
      end
      else
        stable_cnt <= '0;
    end
  end

  assign restart = !spd_s || mode_change;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || restart)
      div_cnt <= '0;
    else if (div_cnt == div_of(active_mode) - 3'h1)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 3'h1;
  end

  assign sample_take = spd_s && !mode_change && (div_cnt == div_of(active_mode) - 3'h1);
  assign next_acc = acc + ACC_W'(sample_in);

  // Boxcar decimator: equal taps give a symmetric response and thus constant group delay.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || restart)
    begin
      acc <= '0;
      sample_cnt <= '0;
      conv_done <= 1'b0;
    end
    else
    begin
      conv_done <= 1'b0;
      if (sample_take)
      begin
        if (sample_cnt == osr_of(active_mode) - 8'h01)
        begin
          acc <= '0;
          sample_cnt <= '0;
          conv_done <= 1'b1;
        end
        else
        begin
          acc <= next_acc;
          sample_cnt <= sample_cnt + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      result_word <= '0;
    else if (sample_take && sample_cnt == osr_of(active_mode) - 8'h01)
      result_word <= clip_result(next_acc >>> shift_of(active_mode));
  end

  // Counts conversions since the last restart, stopping once settled; results are withheld until the filter has settled.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || restart)
    begin
      conv_cnt <= '0;
      settled <= 1'b0;
    end
    else if (conv_done && !settled)
    begin
      conv_cnt <= conv_cnt + 7'h01;
      if (conv_cnt == settle_of(active_mode) - 7'h01)
        settled <= 1'b1;
    end
  end

  assign publish = conv_done && (settled || conv_cnt == settle_of(active_mode) - 7'h01);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || restart)
      ready_state <= RDY_HIGH;
    else
    begin
      case (ready_state)
        RDY_HIGH:
          if (publish)
            ready_state <= RDY_LOAD;
        RDY_LOAD:
          ready_state <= RDY_LOW;
        RDY_LOW:
          if (publish)
            ready_state <= RDY_LOAD;
          else if (sclk_rise)
            ready_state <= RDY_HIGH;
        default:
          ready_state <= RDY_HIGH;
      endcase
    end
  end

  // A load overrides a shift in the same cycle and drops any bits still unsent.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      shifter <= '0;
    else if (!format_s && publish)
      shifter <= result_word;
    else if (format_s && strobe_rise)
      shifter <= settled ? result_word : 24'h00_0000;
    else if (sclk_fall)
      shifter <= {shifter[22:0], chain_s};
  end

  assign link.dout = shifter[23];
  assign link.rf_dev_out = (ready_state != RDY_LOW);
  assign link.rf_dev_oe_n = format_s;

endmodule

// ===== include/adc_port_pkg.sv
// Function
// - Oversampling 128 high-resolution, 64 otherwise.
// - Modulator rate is clock over two or four.
// - Decimation filter has linear phase.
// - Settled after 76 or 78 conversions.
// - Result is 24-bit two's complement.
// - Result saturates at 7FFFFF and 800000.
// - Format input selects SPI or frame-sync pin roles.
// - SPI read-only, MSB first, falling-edge shifting.
// - Host samples data on rising serial clock.
// - Host parks clock low, not above master rate.
// - Free-running or stopped serial clock both work.
// - Host clock is master over power of two.
// - Ready falls on result, rises on clock rise.
// - Unread result gives brief ready high pulse.
// - Shifter loads one cycle before ready falls.
// - Host reads all bits before next load; at master over 16 the host end does so in high-resolution mode only.
// - MSB valid at ready fall, then per fall.
// - After 24 bits, chain input passes through.
// - Chain input sampled on falling serial clock.
// - Single device ties chain input low.
// - Frame-sync: host supplies strobe and clock.
// - Mode change acts after 12,288 stable cycles.
// - After sync release ready waits for settling.
package adc_port_pkg;
  localparam int RESULT_W = 24;
  localparam logic signed [23:0] CODE_MAX = 24'sh7F_FFFF;
  localparam logic signed [23:0] CODE_MIN = 24'sh80_0000;
  localparam logic [1:0] MODE_PIN_HS = 2'h0;
  localparam logic [1:0] MODE_PIN_HR = 2'h1;
  localparam logic [1:0] MODE_PIN_LP = 2'h2;
  localparam logic [7:0] OSR_HS_LP = 8'h40;
  localparam logic [7:0] OSR_HR = 8'h80;
  localparam logic [2:0] OSR_SHIFT_HS_LP = 3'h6;
  localparam logic [2:0] OSR_SHIFT_HR = 3'h7;
  localparam logic [2:0] MOD_DIV_HS = 3'h4;
  localparam logic [2:0] MOD_DIV_HR = 3'h4;
  localparam logic [2:0] MOD_DIV_LP = 3'h2;
  localparam logic [6:0] SETTLE_HS_LP = 7'h4C;
  localparam logic [6:0] SETTLE_HR = 7'h4E;
  localparam int MODE_STABLE_CYCLES = 12288;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCLK_HALF_CYCLES = 8;
  localparam int FRAME_SCLK_PERIODS = 64;
  typedef enum logic [2:0] {MODE_HS = 3'b001, MODE_HR = 3'b010, MODE_LP = 3'b100} op_mode_t;
  typedef enum logic [2:0] {RDY_HIGH = 3'b001, RDY_LOAD = 3'b010, RDY_LOW = 3'b100} ready_state_t;
  typedef enum logic [2:0] {HOST_IDLE = 3'b001, HOST_LOW = 3'b010, HOST_HIGH = 3'b100} host_state_t;
endpackage

// ===== include/adc_link_if.sv
`timescale 1ns/1ps
interface adc_link_if;
  logic sclk;
  logic dout;
  logic chain_in;
  logic rf_dev_out;
  logic rf_dev_oe_n;
  logic rf_host_out;
  logic rf_host_oe_n;
  logic ready_or_frame_pin;

  // Shared ready/frame line: whichever end has its enable low drives it; idle level is high.
  assign ready_or_frame_pin = !rf_dev_oe_n ? rf_dev_out : (!rf_host_oe_n ? rf_host_out : 1'b1);

  modport device(
    input sclk,
    input chain_in,
    input ready_or_frame_pin,
    output dout,
    output rf_dev_out,
    output rf_dev_oe_n
  );
  modport host(
    input dout,
    input ready_or_frame_pin,
    output sclk,
    output rf_host_out,
    output rf_host_oe_n
  );
endinterface

// ===== rtl/adc_host_end.sv
`timescale 1ns/1ps
module adc_host_end
  import adc_port_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_CYCLES,
  parameter int CHAIN_WORDS = 1,
  parameter int FRAME_BITS = FRAME_SCLK_PERIODS
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  adc_link_if.host link,
  input wire logic format_pin,
  input wire logic read_enable,
  output logic [RESULT_W*CHAIN_WORDS-1:0] read_data,
  output logic read_valid,
  output logic busy
);

  localparam int TOTAL = RESULT_W * CHAIN_WORDS;

  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic ready_prev;
  logic ready_fall;
  host_state_t state;
  logic [7:0] half_cnt;
  logic [7:0] bit_cnt;
  logic [TOTAL-1:0] shift_in;
  logic half_end;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pin_meta <= 2'b10;
      pin_sync <= 2'b10;
      ready_prev <= 1'b1;
    end
    else
    begin
      pin_meta <= {link.ready_or_frame_pin, link.dout};
      pin_sync <= pin_meta;
      ready_prev <= pin_sync[1];
    end
  end

  assign ready_fall = !pin_sync[1] && ready_prev;
  assign half_end = (half_cnt == 8'(SCLK_HALF - 1));

  // Clock runs at master over 2*SCLK_HALF; keep SCLK_HALF a power of two.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state <= HOST_IDLE;
      half_cnt <= '0;
      bit_cnt <= '0;
      link.sclk <= 1'b0;
      shift_in <= '0;
      read_data <= '0;
      read_valid <= 1'b0;
    end
    else
    begin
      read_valid <= 1'b0;
      case (state)
        HOST_IDLE:
        begin
          half_cnt <= '0;
          bit_cnt <= '0;
          link.sclk <= 1'b0;
          if (format_pin || (read_enable && ready_fall))
            state <= HOST_LOW;
        end
        HOST_LOW:
        begin
          half_cnt <= half_end ? 8'h00 : half_cnt + 8'h01;
          if (half_end)
          begin
            link.sclk <= 1'b1;
            state <= HOST_HIGH;
            if (bit_cnt < 8'(TOTAL))
              shift_in <= {shift_in[TOTAL-2:0], pin_sync[0]};
            if (bit_cnt == 8'(TOTAL - 1))
            begin
              read_data <= {shift_in[TOTAL-2:0], pin_sync[0]};
              read_valid <= 1'b1;
            end
          end
        end
        HOST_HIGH:
        begin
          half_cnt <= half_end ? 8'h00 : half_cnt + 8'h01;
          if (half_end)
          begin
            link.sclk <= 1'b0;
            if (!format_pin && bit_cnt == 8'(TOTAL - 1))
              state <= HOST_IDLE;
            else
            begin
              state <= HOST_LOW;
              bit_cnt <= (bit_cnt == 8'(FRAME_BITS - 1)) ? 8'h00 : bit_cnt + 8'h01;
            end
          end
        end
        default:
          state <= HOST_IDLE;
      endcase
    end
  end

  assign busy = (state != HOST_IDLE);
  assign link.rf_host_out = format_pin && (state != HOST_IDLE) && (bit_cnt == 8'h00);
  assign link.rf_host_oe_n = !format_pin;

endmodule

// ===== verification/adc_link_chk.sv
`timescale 1ns/1ps
module adc_link_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic dout,
  input wire logic rf_dev_oe_n,
  input wire logic rf_host_oe_n,
  input wire logic ready_or_frame_pin
);
  logic [4:0] age;
  logic [5:0] falls;
  logic [5:0] rises;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Cycles since the serial clock last changed, saturating.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || $changed(sclk))
      age <= '0;
    else if (age != 5'h1F)
      age <= age + 5'h01;
  end

  // Serial clock edges since the ready line last fell, that is since the last load.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || $fell(ready_or_frame_pin))
    begin
      falls <= '0;
      rises <= '0;
    end
    else
    begin
      if ($fell(sclk) && falls != 6'h3F)
        falls <= falls + 6'h01;
      if ($rose(sclk) && rises != 6'h3F)
        rises <= rises + 6'h01;
    end
  end

  property p_roles;
    !rf_dev_oe_n && rf_host_oe_n;
  endproperty
  a_roles: assert property (p_roles) else $error("ready line owner wrong");
  property p_ready_clears;
    $rose(sclk) && !ready_or_frame_pin |-> ##[1:6] ready_or_frame_pin;
  endproperty
  a_ready_clears: assert property (p_ready_clears) else $error("ready not cleared by sclk");
  property p_dout_timing;
    $changed(dout) |-> age <= 5'h06 || ready_or_frame_pin;
  endproperty
  a_dout_timing: assert property (p_dout_timing) else $error("dout moved without shift or load");
  property p_msb_at_ready;
    $fell(ready_or_frame_pin) |-> $stable(dout) && !sclk;
  endproperty
  a_msb_at_ready: assert property (p_msb_at_ready) else $error("msb not set before ready fell");
  property p_sclk_half;
    $changed(sclk) |=> $stable(sclk) [*6];
  endproperty
  a_sclk_half: assert property (p_sclk_half) else $error("sclk half period too short");
  property p_start_on_ready;
    $rose(sclk) && age > 5'h08 |-> !ready_or_frame_pin;
  endproperty
  a_start_on_ready: assert property (p_start_on_ready) else $error("read began without ready");
  property p_park;
    $fell(sclk) && rises == 6'h18 |=> !sclk [*8];
  endproperty
  a_park: assert property (p_park) else $error("sclk not parked low after word");
  property p_chain_zero;
    falls >= 6'h18 && age >= 5'h06 && dout && !$fell(ready_or_frame_pin) |=> $fell(ready_or_frame_pin);
  endproperty
  a_chain_zero: assert property (p_chain_zero) else $error("dout high past result bits");
endmodule

// ===== verification/test_adc_filter_output_serial_port.sv
`timescale 1ns/1ps
module test_adc_filter_output_serial_port
  import adc_port_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] mode_pin = 2'h0;
  logic sync_powerdown_n = 1'b1;
  logic signed [27:0] sample_in = '0;
  logic read_enable = 1'b0;
  logic sample_take;
  op_mode_t active_mode;
  logic settled;
  logic [23:0] read_data;
  logic read_valid;
  logic [23:0] word;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  logic signed [27:0] vals [7] = '{28'sh000_0001, 28'shFFF_FFFF, 28'sh000_0000, 28'sh07F_FFFF,
    28'sh090_0000, 28'shF80_0000, 28'shF00_0000};
  logic [23:0] exps [7] = '{24'h00_0001, 24'hFF_FFFF, 24'h00_0000, 24'h7F_FFFF, 24'h7F_FFFF,
    24'h80_0000, 24'h80_0000};
  adc_link_if link();

  assign link.chain_in = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  adc_device_end #(.MODE_STABLE(16)) adc_device_end_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(link.device),
    .mode_pin(mode_pin), .format_pin(1'b0), .sync_powerdown_n(sync_powerdown_n), .sample_in(sample_in),
    .sample_take(sample_take), .active_mode(active_mode), .settled(settled));
  adc_host_end adc_host_end_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(link.host), .format_pin(1'b0),
    .read_enable(read_enable), .read_data(read_data), .read_valid(read_valid), .busy());
  adc_link_chk adc_link_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(link.sclk), .dout(link.dout),
    .rf_dev_oe_n(link.rf_dev_oe_n), .rf_host_oe_n(link.rf_host_oe_n),
    .ready_or_frame_pin(link.ready_or_frame_pin));

  task automatic finish_test();
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_ready(input logic lvl, output int k);
    k = 0;
    while (link.ready_or_frame_pin !== lvl && k < 2000)
    begin
      @(negedge clk_sys);
      k++;
    end
  endtask

  // Counts modulator samples from a restart until the first result is published.
  task automatic settle(input int osr, input int div, input int conv);
    int k;
    int cnt;
    int first;
    int last;
    k = 0;
    cnt = 0;
    first = 0;
    last = 0;
    while ((k < 8 || link.ready_or_frame_pin !== 1'b0) && k < 45000)
    begin
      @(negedge clk_sys);
      k++;
      if (sample_take === 1'b1)
      begin
        first = (cnt == 0) ? k : first;
        last = k;
        cnt++;
      end
    end
    check(32'(cnt >= osr * conv - 2 && cnt <= osr * conv + 2), 32'h1);
    check(32'(last - first), 32'((cnt - 1) * div));
    check(32'(settled), 32'h1);
  endtask

  task automatic set_mode(input logic [1:0] pin, input op_mode_t m);
    int k;
    k = 0;
    mode_pin = pin;
    while (active_mode !== m && k < 100)
    begin
      @(negedge clk_sys);
      k++;
    end
    check(32'(k >= 16 && k <= 26), 32'h1);
  endtask

  task automatic read_word();
    int k;
    k = 0;
    @(negedge clk_sys);
    read_enable = 1'b1;
    while (read_valid !== 1'b1 && k < 2000)
    begin
      @(negedge clk_sys);
      k++;
    end
    word = read_data;
    read_enable = 1'b0;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      errors++;
      finish_test();
    end
  end

  initial
  begin
    repeat (5) @(negedge clk_sys);
    check(32'(link.ready_or_frame_pin), 32'h1);
    rst_n = 1'b1;
    settle(64, 4, 76);
    set_mode(2'h2, MODE_LP);
    settle(64, 2, 76);
    sync_powerdown_n = 1'b0;
    repeat (6) @(negedge clk_sys);
    check(32'(link.ready_or_frame_pin), 32'h1);
    sync_powerdown_n = 1'b1;
    settle(64, 2, 76);
    set_mode(2'h1, MODE_HR);
    settle(128, 4, 78);
    // The first read may hold a mixed conversion, so only the second is compared.
    for (int i = 0; i < 7; i++)
    begin
      sample_in = vals[i];
      read_word();
      read_word();
      check(32'(word), 32'(exps[i]));
    end
    wait_ready(1'b0, n);
    wait_ready(1'b1, n);
    wait_ready(1'b0, n);
    check(32'(n), 32'h1);
    finish_test();
  end
endmodule
